/* rtl/adf_pkg.sv */
// package: widths, field positions, mode codes and reset values of the output formatter
package adf_pkg;

  // sample, select and phase counter widths
  localparam int unsigned SMP_W    = 8;
  localparam int unsigned SEL_W    = 3;
  localparam int unsigned PHASE_W  = 2;

  // rate divide select codes
  localparam logic [SEL_W-1:0] DIV_SEL_HALF    = 3'h2;
  localparam logic [SEL_W-1:0] DIV_SEL_QUARTER = 3'h4;

  // positions of the fields in the synchronised input vector
  localparam int unsigned POS_SCLK   = 0;
  localparam int unsigned POS_DATA   = 1;
  localparam int unsigned POS_OVR    = POS_DATA + SMP_W;
  localparam int unsigned POS_SPLIT  = POS_OVR + 1;
  localparam int unsigned POS_AUXA   = POS_SPLIT + 1;
  localparam int unsigned POS_AUXB   = POS_AUXA + 1;
  localparam int unsigned POS_SEL    = POS_AUXB + 1;
  localparam int unsigned POS_RSTP   = POS_SEL + SEL_W;
  localparam int unsigned POS_RSTN   = POS_RSTP + 1;
  localparam int unsigned SYNC_W     = POS_RSTN + 1;

  // sample phase positions inside a pairing sequence
  localparam logic [PHASE_W-1:0] PH_FIRST  = 2'h0;
  localparam logic [PHASE_W-1:0] PH_SECOND = 2'h1;
  localparam logic [PHASE_W-1:0] PH_THIRD  = 2'h2;

  // reset values
  localparam logic [SMP_W-1:0]   PORT_RST   = 8'h00;
  localparam logic [SYNC_W-1:0]  SYNC_RST   = 18'h0_0000;
  localparam logic [PHASE_W-1:0] PHASE_RST  = 2'h0;

  typedef enum logic [1:0] {
    ADF_DIRECT,
    ADF_HALF,
    ADF_QUARTER
  } adf_mode_t;

  // split enable off wins; an unknown select with split on acts as half rate
  function automatic adf_mode_t adf_decode_mode(input logic split_on, input logic [SEL_W-1:0] sel);
    adf_mode_t m;
    m = ADF_DIRECT;
    if (!split_on) begin
      m = ADF_DIRECT;
    end else if (sel == DIV_SEL_QUARTER) begin
      m = ADF_QUARTER;
    end else begin
      m = ADF_HALF;
    end
    return m;
  endfunction : adf_decode_mode

endpackage : adf_pkg

/* rtl/adf_sync.sv */
// module: two flip-flop synchroniser for a vector of pin-level inputs
module adf_sync
  import adf_pkg::*;
#(
  parameter int unsigned W = SYNC_W
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule : adf_sync

/* rtl/adf_diff_reg.sv */
// module: registered true/complement output pair with a pull-up shutdown
module adf_diff_reg #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  input  wire logic         off_i,
  output logic      [W-1:0] p_o,
  output logic      [W-1:0] n_o
);

  logic [W-1:0] p_reg;
  logic [W-1:0] n_reg;
  logic [W-1:0] p_next;
  logic [W-1:0] n_next;

  // a shut-down port lets both phases float up, so both read high
  always_comb begin
    p_next = d_i | {W{off_i}};
    n_next = ~d_i | {W{off_i}};
  end

  // reset shows a clean logic zero on every pair
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      p_reg <= '0;
      n_reg <= '1;
    end else begin
      p_reg <= p_next;
      n_reg <= n_next;
    end
  end

  assign p_o = p_reg;
  assign n_o = n_reg;

endmodule : adf_diff_reg

/* rtl/adf_formatter.sv */
// module: output demultiplexer and formatter of the converter's sample ports
//
// Operation
// R1: half-rate mode puts two consecutive samples on both ports, one strobe each.
// R2: controller selects half rate with split and both auxiliary enables on, select 2.
// R3: split off means direct mode, primary port only, divide select ignored.
// R4: two auxiliary enables; off in direct mode shuts the auxiliary port down.
// R5: quarter-rate mode drops every other sample, pairs the rest across both ports.
// R6: controller selects quarter rate with split and both enables on, select 4.
// R7: one differential overrange flag serves both primary and auxiliary ports.
// R8: in split modes overrange flags when either port sample is out of range.
// R9: in direct mode overrange follows only the primary port sample.
// R10: samples are taken on the rising edge of the true sample clock phase.
// R11: data and overrange change on strobe rise; receiver captures on strobe fall.
// R12: while the splitter reset is asserted the demultiplexer state is reset.
// R13: a differential reset output resets external demultiplexers in step.
// R14: sample-to-port order never depends on the strobe phase.
// R15: an undriven reset input reads as deasserted.
// R16: mode table: split off direct; on with 2 half; on with 4 quarter.
// R17: each port is bit 0 lsb to bit 7 msb, true and complement outputs.
// R18: in split modes the earlier sample goes primary, the later auxiliary.
// R19: after reset release pairing restarts at a known phase; reset out follows in.
module adf_formatter
  import adf_pkg::*;
(
  input  wire logic             REF_CLK_I,
  input  wire logic             RESET_N_I,
  input  wire logic             SAMPLE_CLK_P_I,
  input  wire logic [SMP_W-1:0] SAMPLE_DATA_I,
  input  wire logic             SAMPLE_OVR_I,
  input  wire logic             SPLIT_OUTPUT_ENABLE_I,
  input  wire logic             SECOND_PORT_ON_A_I,
  input  wire logic             SECOND_PORT_ON_B_I,
  input  wire logic [SEL_W-1:0] RATE_DIVIDE_SELECT_I,
  input  wire logic             SPLITTER_RESET_IN_P_I,
  input  wire logic             SPLITTER_RESET_IN_N_I,
  output logic      [SMP_W-1:0] PRIMARY_PORT_BIT_P_O,
  output logic      [SMP_W-1:0] PRIMARY_PORT_BIT_N_O,
  output logic      [SMP_W-1:0] AUXILIARY_PORT_BIT_P_O,
  output logic      [SMP_W-1:0] AUXILIARY_PORT_BIT_N_O,
  output logic                  OVERRANGE_P_O,
  output logic                  OVERRANGE_N_O,
  output logic                  OUTPUT_STROBE_P_O,
  output logic                  OUTPUT_STROBE_N_O,
  output logic                  SPLITTER_RESET_OUT_P_O,
  output logic                  SPLITTER_RESET_OUT_N_O
);

  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------

  logic [SYNC_W-1:0] pins_async;
  logic [SYNC_W-1:0] pins_sync;

  // every pin crosses through the same two stages, so data and clock
  // keep their relative timing; data must be stable around the rising
  // sample clock edge for at least one reference clock period
  assign pins_async = {SPLITTER_RESET_IN_N_I,
                       SPLITTER_RESET_IN_P_I,
                       RATE_DIVIDE_SELECT_I,
                       SECOND_PORT_ON_B_I,
                       SECOND_PORT_ON_A_I,
                       SPLIT_OUTPUT_ENABLE_I,
                       SAMPLE_OVR_I,
                       SAMPLE_DATA_I,
                       SAMPLE_CLK_P_I};

  adf_sync #(
    .W (SYNC_W)
  ) u_pin_sync (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RESET_N_I),
    .async_i (pins_async),
    .sync_o  (pins_sync)
  );

  // unpacked synchronised fields
  logic             s_sclk;
  logic [SMP_W-1:0] s_data;
  logic             s_ovr;
  logic             s_split;
  logic             s_aux_a;
  logic             s_aux_b;
  logic [SEL_W-1:0] s_sel;
  logic             s_rst_p;
  logic             s_rst_n;

  assign s_sclk  = pins_sync[POS_SCLK];
  assign s_data  = pins_sync[POS_DATA +: SMP_W];
  assign s_ovr   = pins_sync[POS_OVR];
  assign s_split = pins_sync[POS_SPLIT];
  assign s_aux_a = pins_sync[POS_AUXA];
  assign s_aux_b = pins_sync[POS_AUXB];
  assign s_sel   = pins_sync[POS_SEL +: SEL_W];
  assign s_rst_p = pins_sync[POS_RSTP];
  assign s_rst_n = pins_sync[POS_RSTN];

  // ---------------------------------------------------------------
  // sample clock edge detection and control decode
  // ---------------------------------------------------------------

  logic      sclk_d_reg;
  logic      sclk_d_next;
  logic      sclk_rise;
  logic      sclk_fall;
  logic      splitter_rst;
  logic      aux_off;
  adf_mode_t mode;

  // edges of the true clock phase, seen after synchronisation
  always_comb begin
    sclk_d_next = s_sclk;
    sclk_rise   = s_sclk & ~sclk_d_reg;                            // R10
    sclk_fall   = ~s_sclk & sclk_d_reg;
  end

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sclk_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_d_next;
    end
  end

  // an open input self-biases with the true leg below the complement,
  // which reads as p=0/n=1 and so never asserts
  assign splitter_rst = s_rst_p & ~s_rst_n;                        // R15

  // mode table; the select is only looked at with split enabled
  assign mode = adf_decode_mode(s_split, s_sel);                   // R16 R3

  // either auxiliary enable off in direct mode powers the port down
  assign aux_off = (mode == ADF_DIRECT) & (~s_aux_a | ~s_aux_b);   // R4

  // ---------------------------------------------------------------
  // demultiplexer state
  // ---------------------------------------------------------------

  logic [PHASE_W-1:0] phase_reg;
  logic [PHASE_W-1:0] phase_next;
  adf_mode_t          mode_reg;
  adf_mode_t          mode_next;
  logic [SMP_W-1:0]   held_data_reg;
  logic [SMP_W-1:0]   held_data_next;
  logic               held_ovr_reg;
  logic               held_ovr_next;
  logic [SMP_W-1:0]   pri_reg;
  logic [SMP_W-1:0]   pri_next;
  logic [SMP_W-1:0]   aux_reg;
  logic [SMP_W-1:0]   aux_next;
  logic               ovr_reg;
  logic               ovr_next;
  logic               strobe_reg;
  logic               strobe_next;
  logic               rst_out_reg;
  logic               rst_out_next;

  // the phase counter counts samples, not strobes, so the port order
  // stays fixed whatever the strobe phase happens to be
  always_comb begin
    phase_next     = phase_reg;
    mode_next      = mode;
    held_data_next = held_data_reg;
    held_ovr_next  = held_ovr_reg;
    pri_next       = pri_reg;
    aux_next       = aux_reg;
    ovr_next       = ovr_reg;
    strobe_next    = strobe_reg;
    if (splitter_rst) begin
      // hold pairing at its first phase for as long as reset stands
      phase_next  = PHASE_RST;                                     // R12 R19
      strobe_next = 1'b0;
    end else if (mode != mode_reg) begin
      // a mode change restarts pairing rather than mixing sequences
      phase_next  = PHASE_RST;
      strobe_next = 1'b0;
    end else if (sclk_rise) begin
      case (mode)
        ADF_DIRECT: begin
          // every sample lands on the primary port alone
          pri_next    = s_data;                                    // R3 R17
          ovr_next    = s_ovr;                                     // R9 R7
          strobe_next = 1'b1;                                      // R11
          phase_next  = PHASE_RST;
        end
        ADF_HALF: begin
          if (phase_reg == PH_FIRST) begin
            // earlier sample waits; strobe falls mid window
            held_data_next = s_data;
            held_ovr_next  = s_ovr;
            strobe_next    = 1'b0;                                 // R11
            phase_next     = PH_SECOND;
          end else begin
            // later sample completes the pair, both ports update
            pri_next    = held_data_reg;                           // R1 R18 R14
            aux_next    = s_data;                                  // R1 R18
            ovr_next    = held_ovr_reg | s_ovr;                    // R8 R7
            strobe_next = 1'b1;                                    // R11 R1
            phase_next  = PH_FIRST;
          end
        end
        ADF_QUARTER: begin
          case (phase_reg)
            PH_FIRST: begin
              held_data_next = s_data;
              held_ovr_next  = s_ovr;
              strobe_next    = 1'b0;                               // R11
            end
            PH_THIRD: begin
              pri_next    = held_data_reg;                         // R5 R18 R14
              aux_next    = s_data;                                // R5 R18
              ovr_next    = held_ovr_reg | s_ovr;                  // R8
              strobe_next = 1'b1;                                  // R11 R5
            end
            default: begin
              // odd samples are dropped, ports untouched
              held_data_next = held_data_reg;                      // R5
            end
          endcase
          phase_next = PHASE_W'(phase_reg + 2'h1);
        end
        default: begin
          phase_next = PHASE_RST;
        end
      endcase
    end else if (sclk_fall && (mode == ADF_DIRECT)) begin
      // in direct mode the strobe falls half a sample period in
      strobe_next = 1'b0;                                          // R11
    end
  end

  // the reset output is a registered copy of the synchronised input;
  // after the output register it reaches the pins one edge after this demultiplexer resets
  assign rst_out_next = splitter_rst;                              // R13 R19

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      phase_reg     <= PHASE_RST;
      mode_reg      <= ADF_DIRECT;
      held_data_reg <= PORT_RST;
      held_ovr_reg  <= 1'b0;
      pri_reg       <= PORT_RST;
      aux_reg       <= PORT_RST;
      ovr_reg       <= 1'b0;
      strobe_reg    <= 1'b0;
      rst_out_reg   <= 1'b0;
    end else begin
      phase_reg     <= phase_next;
      mode_reg      <= mode_next;
      held_data_reg <= held_data_next;
      held_ovr_reg  <= held_ovr_next;
      pri_reg       <= pri_next;
      aux_reg       <= aux_next;
      ovr_reg       <= ovr_next;
      strobe_reg    <= strobe_next;
      rst_out_reg   <= rst_out_next;
    end
  end

  // ---------------------------------------------------------------
  // differential output stage
  // ---------------------------------------------------------------

  // all pairs pass one common register so data, flag and strobe stay
  // time-aligned; the strobe fall then sits mid data window
  adf_diff_reg #(
    .W (SMP_W)
  ) u_pri_out (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RESET_N_I),
    .d_i     (pri_reg),
    .off_i   (1'b0),
    .p_o     (PRIMARY_PORT_BIT_P_O),                               // R17
    .n_o     (PRIMARY_PORT_BIT_N_O)
  );

  adf_diff_reg #(
    .W (SMP_W)
  ) u_aux_out (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RESET_N_I),
    .d_i     (aux_reg),
    .off_i   (aux_off),                                            // R4
    .p_o     (AUXILIARY_PORT_BIT_P_O),
    .n_o     (AUXILIARY_PORT_BIT_N_O)
  );

  // one flag for both ports
  adf_diff_reg #(
    .W (1)
  ) u_ovr_out (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RESET_N_I),
    .d_i     (ovr_reg),                                            // R7
    .off_i   (1'b0),
    .p_o     (OVERRANGE_P_O),
    .n_o     (OVERRANGE_N_O)
  );

  adf_diff_reg #(
    .W (1)
  ) u_strobe_out (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RESET_N_I),
    .d_i     (strobe_reg),                                         // R11
    .off_i   (1'b0),
    .p_o     (OUTPUT_STROBE_P_O),
    .n_o     (OUTPUT_STROBE_N_O)
  );

  adf_diff_reg #(
    .W (1)
  ) u_rst_out (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RESET_N_I),
    .d_i     (rst_out_reg),                                        // R13
    .off_i   (1'b0),
    .p_o     (SPLITTER_RESET_OUT_P_O),
    .n_o     (SPLITTER_RESET_OUT_N_O)
  );

endmodule : adf_formatter

/* testbench/adf_formatter_sva.sv */
// checker: port-level timing and pairing relations of the output formatter
module adf_formatter_sva
  import adf_pkg::*;
(
  input wire logic             REF_CLK_I,
  input wire logic             RESET_N_I,
  input wire logic             SAMPLE_CLK_P_I,
  input wire logic             SPLIT_OUTPUT_ENABLE_I,
  input wire logic             SECOND_PORT_ON_A_I,
  input wire logic             SECOND_PORT_ON_B_I,
  input wire logic             SPLITTER_RESET_IN_P_I,
  input wire logic             SPLITTER_RESET_IN_N_I,
  input wire logic [SMP_W-1:0] PRIMARY_PORT_BIT_P_O,
  input wire logic [SMP_W-1:0] PRIMARY_PORT_BIT_N_O,
  input wire logic [SMP_W-1:0] AUXILIARY_PORT_BIT_P_O,
  input wire logic [SMP_W-1:0] AUXILIARY_PORT_BIT_N_O,
  input wire logic             OVERRANGE_P_O,
  input wire logic             OVERRANGE_N_O,
  input wire logic             OUTPUT_STROBE_P_O,
  input wire logic             OUTPUT_STROBE_N_O,
  input wire logic             SPLITTER_RESET_OUT_P_O,
  input wire logic             SPLITTER_RESET_OUT_N_O
);
  timeunit 1ns;
  timeprecision 1ps;
  // splitter reset counts as asserted only for true high, complement low
  wire logic rst_in = SPLITTER_RESET_IN_P_I & ~SPLITTER_RESET_IN_N_I;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // six edges give the two sync stages plus output register some margin
  property p_pri_pair; PRIMARY_PORT_BIT_N_O == ~PRIMARY_PORT_BIT_P_O; endproperty
  a_pri_pair: assert property (p_pri_pair) else $error("primary pair not complementary");
  property p_flag_pair;
    OVERRANGE_N_O == !OVERRANGE_P_O && OUTPUT_STROBE_N_O == !OUTPUT_STROBE_P_O;
  endproperty
  a_flag_pair: assert property (p_flag_pair) else $error("flag pair not complementary");
  property p_aux_off;
    (!SPLIT_OUTPUT_ENABLE_I && !(SECOND_PORT_ON_A_I && SECOND_PORT_ON_B_I)) [*6]
      |-> &{AUXILIARY_PORT_BIT_P_O, AUXILIARY_PORT_BIT_N_O};
  endproperty
  a_aux_off: assert property (p_aux_off) else $error("auxiliary port not shut down");
  // split modes never shut the port down; four edges cover sync and output register
  property p_aux_pair; SPLIT_OUTPUT_ENABLE_I [*4] |-> AUXILIARY_PORT_BIT_N_O == ~AUXILIARY_PORT_BIT_P_O; endproperty
  a_aux_pair: assert property (p_aux_pair) else $error("auxiliary pair not complementary");
  property p_rst_out; rst_in [*6] |-> SPLITTER_RESET_OUT_P_O && !SPLITTER_RESET_OUT_N_O; endproperty
  a_rst_out: assert property (p_rst_out) else $error("reset out not following");
  property p_rst_strobe; rst_in [*6] |-> !OUTPUT_STROBE_P_O; endproperty
  a_rst_strobe: assert property (p_rst_strobe) else $error("strobe running in reset");
  property p_launch;
    ($changed(PRIMARY_PORT_BIT_P_O) || $changed(OVERRANGE_P_O)) |-> $rose(OUTPUT_STROBE_P_O);
  endproperty
  a_launch: assert property (p_launch) else $error("data changed off strobe rise");
  property p_split_hold; SPLIT_OUTPUT_ENABLE_I && $rose(OUTPUT_STROBE_P_O) |-> OUTPUT_STROBE_P_O [*6]; endproperty
  a_split_hold: assert property (p_split_hold) else $error("split strobe too short");
  property p_direct_rate;
    $rose(SAMPLE_CLK_P_I) && !SPLIT_OUTPUT_ENABLE_I && !rst_in |-> ##[2:7] $rose(OUTPUT_STROBE_P_O);
  endproperty
  a_direct_rate: assert property (p_direct_rate) else $error("no strobe per sample");
endmodule : adf_formatter_sva

/* testbench/adf_capture.sv */
// partner: receiver latching both ports and the flag on the strobe fall
module adf_capture
  import adf_pkg::*;
(
  input wire logic             strobe_i,
  input wire logic [SMP_W-1:0] pri_i,
  input wire logic [SMP_W-1:0] aux_i,
  input wire logic             ovr_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [16:0] cap_q[$];
  // fall sits mid data window, so no setup race with the launching rise
  always @(negedge strobe_i) begin
    cap_q.push_back({ovr_i, aux_i, pri_i});
  end
endmodule : adf_capture

/* testbench/adf_formatter_tb.sv */
// testbench: mode table, pairing, decimation, overrange and splitter reset
module adf_formatter_tb
  import adf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk, rst_n, sclk, ovr, split, aua, aub, rp, rn;
  logic [SMP_W-1:0] data, lfsr, pp, pn, ap, an;
  logic [SEL_W-1:0] sel;
  logic             op, on, stp, stn, rop, ron;
  int               bad_count, checked, t;
  int               cyc = 0;
  // rows: split, enable a, enable b, select; direct rows use an ignored select
  logic [5:0]       rows[5] = '{6'h0C, 6'h12, 6'h3A, 6'h3C, 6'h3B};

  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end

  adf_formatter dut_u (.REF_CLK_I(clk), .RESET_N_I(rst_n), .SAMPLE_CLK_P_I(sclk), .SAMPLE_DATA_I(data),
    .SAMPLE_OVR_I(ovr), .SPLIT_OUTPUT_ENABLE_I(split), .SECOND_PORT_ON_A_I(aua), .SECOND_PORT_ON_B_I(aub),
    .RATE_DIVIDE_SELECT_I(sel), .SPLITTER_RESET_IN_P_I(rp), .SPLITTER_RESET_IN_N_I(rn),
    .PRIMARY_PORT_BIT_P_O(pp), .PRIMARY_PORT_BIT_N_O(pn), .AUXILIARY_PORT_BIT_P_O(ap),
    .AUXILIARY_PORT_BIT_N_O(an), .OVERRANGE_P_O(op), .OVERRANGE_N_O(on), .OUTPUT_STROBE_P_O(stp),
    .OUTPUT_STROBE_N_O(stn), .SPLITTER_RESET_OUT_P_O(rop), .SPLITTER_RESET_OUT_N_O(ron));

  adf_capture cap_u (.strobe_i(stp), .pri_i(pp), .aux_i(ap), .ovr_i(op));

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick

  task automatic cmp_word(input logic [16:0] exp, input logic [16:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmp_word

  task automatic cmp_lvl(input logic [15:0] exp, input logic [15:0] got);
    cmp_word({1'b0, exp}, {1'b0, got});
  endtask : cmp_lvl

  // reference model: keep samples, drop odd ones when decimating, pair in split modes
  task automatic burst(input int n);
    logic [8:0]  kept[$];
    logic [16:0] ex;
    logic        qd;
    int          i;
    int          nexp;
    qd = split && sel == DIV_SEL_QUARTER;
    cap_u.cap_q.delete();
    // split modes need one extra rise to drop the strobe of the last pair
    for (i = 0; i < n + (split ? 1 : 0); i++) begin
      lfsr = lfsr_next(lfsr);
      data = lfsr;
      ovr = lfsr[0] & lfsr[3];
      sclk = 0;
      if (i < n && !(qd && i[0])) kept.push_back({ovr, data});
      tick(4);
      sclk = 1;
      tick(4);
    end
    sclk = 0;
    tick(20);
    nexp = split ? kept.size() / 2 : kept.size();
    cmp_word(17'(nexp), 17'(cap_u.cap_q.size()));
    for (i = 0; i < nexp; i++) begin
      if (!split) ex = {kept[i][8], 8'h00, kept[i][7:0]};
      else ex = {kept[2*i][8] | kept[2*i+1][8], kept[2*i+1][7:0], kept[2*i][7:0]};
      cmp_word(ex, cap_u.cap_q[i] & (split ? 17'h1_FFFF : 17'h1_00FF));
    end
  endtask : burst

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  // watchdog: whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      test_done();
    end
  end

  initial begin
    rst_n = 0;
    sclk = 0;
    data = 8'h00;
    ovr = 0;
    {split, aua, aub, sel} = 6'h3A;
    rp = 0;
    rn = 1;
    lfsr = 8'h60;
    repeat (16) @(posedge clk);
    #2;
    rst_n = 1;
    tick(8);
    for (t = 0; t < 5; t++) begin
      {split, aua, aub, sel} = rows[t];
      rp = 1;
      rn = 0;
      tick(8);
      cmp_lvl(16'h0004, {13'h0000, rop, ron, stp});
      rp = 0;
      rn = 1;
      tick(8);
      cmp_lvl(16'h0002, {13'h0000, rop, ron, stp});
      burst(8);
      if (!split) cmp_lvl(16'hFFFF, {ap, an});
      $display("test %0d done", t);
    end
    test_done();
  end
endmodule : adf_formatter_tb

bind adf_formatter adf_formatter_sva chk_u (.*);
